// File: design/tap_instruction_scan_tail.sv
// test access port controller with instruction scan path and system-clock handoff
module tap_instruction_scan_tail
  import tap_scan_pkg::*;
(
  // system clock and reset
  input wire logic clk,
  input wire logic reset,
  // test port
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe_n,
  // test clock domain status
  output tap_state_e tap_state,
  output instr_t active_instr,
  output dr_t data_reg,
  // system clock domain
  output instr_t sys_instr,
  output logic sys_instr_strobe
);
  typedef struct packed {
    tap_state_e state;
    instr_t ir_shift;
    dr_t dr_shift;
    logic bypass;
    logic req;
    logic pend;
    instr_t xfer;
    logic [SYNC_STAGES-1:0] ack_sync;
    logic ack_seen;
  } tck_s;

  typedef struct packed {
    logic [SYNC_STAGES-1:0] req_sync;
    logic req_seen;
    logic ack;
    instr_t instr;
    logic strobe;
  } sys_s;

  tck_s t;
  tck_s next_t;
  sys_s s;
  sys_s next_s;
  logic serial_out;
  logic shift_phase;
  logic data_selected;
  logic new_word;
  logic send;

  // rising-edge controller
  always_comb begin
    next_t = t;
    data_selected = (active_instr == INSTR_DATA);
    case (t.state)
      TEST_LOGIC_RESET: begin
        next_t.state = tms ? TEST_LOGIC_RESET : RUN_IDLE;
      end
      RUN_IDLE: begin
        next_t.state = tms ? SELECT_DR : RUN_IDLE;
      end
      SELECT_DR: begin
        next_t.state = tms ? SELECT_IR : CAPTURE_DR;
      end
      CAPTURE_DR: begin
        if (!data_selected) begin
          next_t.bypass = 1'b0;
        end
        next_t.state = tms ? EXIT1_DR : SHIFT_DR;
      end
      SHIFT_DR: begin
        if (data_selected) begin
          next_t.dr_shift = {tdi, t.dr_shift[DR_LEN-1:1]};
        end else begin
          next_t.bypass = tdi;
        end
        next_t.state = tms ? EXIT1_DR : SHIFT_DR;
      end
      EXIT1_DR: begin
        next_t.state = tms ? UPDATE_DR : PAUSE_DR;
      end
      PAUSE_DR: begin
        next_t.state = tms ? EXIT2_DR : PAUSE_DR;
      end
      EXIT2_DR: begin
        next_t.state = tms ? UPDATE_DR : SHIFT_DR;
      end
      UPDATE_DR: begin
        next_t.state = tms ? SELECT_DR : RUN_IDLE;
      end
      SELECT_IR: begin
        next_t.state = tms ? TEST_LOGIC_RESET : CAPTURE_IR;
      end
      CAPTURE_IR: begin
        next_t.ir_shift = IR_CAPTURE_VALUE;
        next_t.state = tms ? EXIT1_IR : SHIFT_IR;
      end
      SHIFT_IR: begin
        next_t.ir_shift = {tdi, t.ir_shift[IR_LEN-1:1]};
        next_t.state = tms ? EXIT1_IR : SHIFT_IR;
      end
      EXIT1_IR: begin
        next_t.state = tms ? UPDATE_IR : PAUSE_IR;
      end
      PAUSE_IR: begin
        // shift registers untouched here
        next_t.state = tms ? EXIT2_IR : PAUSE_IR;
      end
      EXIT2_IR: begin
        next_t.state = tms ? UPDATE_IR : SHIFT_IR;
      end
      UPDATE_IR: begin
        // data registers untouched here
        next_t.state = tms ? SELECT_DR : RUN_IDLE;
      end
      default: begin
        next_t.state = TEST_LOGIC_RESET;
      end
    endcase
    // word handoff: latched instruction is valid by the rising edge still in update
    new_word = (t.state == UPDATE_IR);
    send = (t.pend || new_word) && (t.req == t.ack_seen);
    next_t.pend = (t.pend || new_word) && !send;
    if (send) begin
      next_t.xfer = active_instr;
      next_t.req = ~t.req;
    end
    next_t.ack_sync = {t.ack_sync[SYNC_STAGES-2:0], s.ack};
    if (t.ack_sync[1] == t.ack_sync[2]) begin
      next_t.ack_seen = t.ack_sync[2];
    end
  end

  always_ff @(posedge tck or posedge reset) begin
    if (reset) begin
      t <= '{state: TEST_LOGIC_RESET, dr_shift: DR_RESET_VALUE, default: '0};
    end else begin
      t <= next_t;
    end
  end

  // system side of the handshake; xfer is stable until ack returns
  always_comb begin
    next_s = s;
    next_s.strobe = 1'b0;
    next_s.req_sync = {s.req_sync[SYNC_STAGES-2:0], t.req};
    if (s.req_sync[1] == s.req_sync[2] && s.req_sync[2] != s.req_seen) begin
      next_s.req_seen = s.req_sync[2];
      next_s.instr = t.xfer;
      next_s.strobe = 1'b1;
      next_s.ack = s.req_sync[2];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s <= '{instr: INSTR_RESET_VALUE, default: '0};
    end else begin
      s <= next_s;
    end
  end

  always_comb begin
    shift_phase = (t.state == SHIFT_IR) || (t.state == SHIFT_DR);
    if (t.state == SHIFT_IR) begin
      serial_out = t.ir_shift[0];
    end else if (data_selected) begin
      serial_out = t.dr_shift[0];
    end else begin
      serial_out = t.bypass;
    end
  end

  ir_update_latch u_latch (
    .tck(tck),
    .reset(reset),
    .in_update_ir(t.state == UPDATE_IR),
    .in_reset_state(t.state == TEST_LOGIC_RESET),
    .ir_shift(t.ir_shift),
    .serial_out(serial_out),
    .shift_phase(shift_phase),
    .active_instr(active_instr),
    .tdo(tdo),
    .tdo_oe_n(tdo_oe_n)
  );

  assign tap_state = t.state;
  assign data_reg = t.dr_shift;
  assign sys_instr = s.instr;
  assign sys_instr_strobe = s.strobe;

  AST_PAUSE_STAYS: assert property (
    @(posedge tck) disable iff (reset)
    t.state == PAUSE_IR && !tms |=> t.state == PAUSE_IR)
    else $error("left instruction pause with mode-select low");

  AST_PAUSE_TO_EXIT2: assert property (
    @(posedge tck) disable iff (reset)
    t.state == PAUSE_IR && tms |=> t.state == EXIT2_IR)
    else $error("pause did not move to second exit");

  AST_EXIT2_TO_UPDATE: assert property (
    @(posedge tck) disable iff (reset)
    t.state == EXIT2_IR && tms |=> t.state == UPDATE_IR ##1 $changed(t.state))
    else $error("second exit did not reach update");

  AST_EXIT2_TO_SHIFT: assert property (
    @(posedge tck) disable iff (reset)
    t.state == EXIT2_IR && !tms |=> t.state == SHIFT_IR)
    else $error("second exit did not resume shifting");

  AST_HOLD_IN_PAUSE_EXIT2: assert property (
    @(posedge tck) disable iff (reset)
    t.state inside {PAUSE_IR, EXIT2_IR} |-> $stable(active_instr) ##1
      ($stable(t.dr_shift) && $stable(t.bypass) && $stable(t.ir_shift)))
    else $error("registers changed during pause or second exit");

  AST_INSTR_SELECTS_DR: assert property (
    @(posedge tck) disable iff (reset)
    t.state == SHIFT_DR && active_instr == INSTR_DATA |=>
      t.dr_shift[DR_LEN-1] == $past(tdi) && $stable(t.bypass))
    else $error("active instruction did not select the data register");

  AST_DR_HELD_IN_UPDATE: assert property (
    @(posedge tck) disable iff (reset)
    t.state == UPDATE_IR |=> $stable(t.dr_shift) && $stable(t.bypass))
    else $error("data register changed in instruction update");

  AST_EXIT1_TO_PAUSE: assert property (
    @(posedge tck) disable iff (reset)
    t.state == EXIT1_IR && !tms |=> t.state == PAUSE_IR)
    else $error("first exit did not enter pause");

  AST_CAPTURE_PATTERN: assert property (
    @(posedge tck) disable iff (reset)
    t.state == CAPTURE_IR |=> t.ir_shift == IR_CAPTURE_VALUE)
    else $error("capture did not load the fixed pattern");

  AST_UPDATE_EXIT: assert property (
    @(posedge tck) disable iff (reset)
    t.state == UPDATE_IR |=> t.state == ($past(tms) ? SELECT_DR : RUN_IDLE))
    else $error("wrong state after instruction update");

  AST_SYS_STROBE_ONE_CYCLE: assert property (
    @(posedge clk) disable iff (reset)
    sys_instr_strobe |=> !sys_instr_strobe)
    else $error("system strobe longer than one cycle");

  COV_PAUSE_RESUME: cover property (
    @(posedge tck) disable iff (reset)
    t.state == PAUSE_IR ##1 t.state == EXIT2_IR ##1 t.state == SHIFT_IR);

  COV_PAUSE_UPDATE: cover property (
    @(posedge tck) disable iff (reset)
    t.state == EXIT2_IR ##1 t.state == UPDATE_IR ##1 t.state == SELECT_DR);

  COV_SYS_HANDOFF: cover property (
    @(posedge clk) disable iff (reset)
    sys_instr_strobe && sys_instr == INSTR_DATA);
endmodule : tap_instruction_scan_tail

// File: inc/tap_scan_pkg.sv
// constants, state codes and types shared by the test access port files
package tap_scan_pkg;
  localparam int IR_LEN = 3;
  localparam int DR_LEN = 8;
  typedef logic [IR_LEN-1:0] instr_t;
  typedef logic [DR_LEN-1:0] dr_t;
  localparam instr_t IR_CAPTURE_VALUE = 3'h4;
  localparam instr_t INSTR_DATA = 3'h1;
  localparam instr_t INSTR_BYPASS = 3'h7;
  localparam instr_t INSTR_RESET_VALUE = INSTR_BYPASS;
  localparam dr_t DR_RESET_VALUE = 8'h00;
  localparam int SYNC_STAGES = 3;
  typedef enum logic [3:0] {
    TEST_LOGIC_RESET = 4'h0,
    RUN_IDLE = 4'h1,
    SELECT_DR = 4'h2,
    CAPTURE_DR = 4'h3,
    SHIFT_DR = 4'h4,
    EXIT1_DR = 4'h5,
    PAUSE_DR = 4'h6,
    EXIT2_DR = 4'h7,
    UPDATE_DR = 4'h8,
    SELECT_IR = 4'h9,
    CAPTURE_IR = 4'hA,
    SHIFT_IR = 4'hB,
    EXIT1_IR = 4'hC,
    PAUSE_IR = 4'hD,
    EXIT2_IR = 4'hE,
    UPDATE_IR = 4'hF
  } tap_state_e;
endpackage : tap_scan_pkg

// File: design/ir_update_latch.sv
// falling-edge instruction latch and serial output stage
module ir_update_latch
  import tap_scan_pkg::*;
(
  // test clock and reset
  input wire logic tck,
  input wire logic reset,
  // from the rising-edge controller
  input wire logic in_update_ir,
  input wire logic in_reset_state,
  input wire instr_t ir_shift,
  input wire logic serial_out,
  input wire logic shift_phase,
  // outputs
  output instr_t active_instr,
  output logic tdo,
  output logic tdo_oe_n
);
  typedef struct packed {
    instr_t active;
    logic tdo;
    logic oe_n;
  } latch_s;

  latch_s q;
  latch_s next_q;

  always_comb begin
    next_q = q;
    if (in_reset_state) begin
      next_q.active = INSTR_RESET_VALUE;
    end else if (in_update_ir) begin
      next_q.active = ir_shift;
    end
    next_q.tdo = shift_phase ? serial_out : 1'b0;
    next_q.oe_n = ~shift_phase;
  end

  always_ff @(negedge tck or posedge reset) begin
    if (reset) begin
      q <= '{active: INSTR_RESET_VALUE, tdo: 1'b0, oe_n: 1'b1};
    end else begin
      q <= next_q;
    end
  end

  assign active_instr = q.active;
  assign tdo = q.tdo;
  assign tdo_oe_n = q.oe_n;

  AST_IR_LATCHED_ON_FALL: assert property (
    @(negedge tck) disable iff (reset)
    in_update_ir && !in_reset_state |=> active_instr == $past(ir_shift))
    else $error("instruction not latched on falling edge in update");

  AST_IR_HELD_ELSEWHERE: assert property (
    @(negedge tck) disable iff (reset)
    !in_update_ir && !in_reset_state |=> $stable(active_instr))
    else $error("active instruction changed outside update");
endmodule : ir_update_latch

// File: sim/tap_tester.sv
// external test controller model driving test clock, mode select and serial data
module tap_tester (
  // test port
  output logic tck,
  output logic tms,
  output logic tdi
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // one 30 ns test clock cycle; clock rests low between calls
  task automatic step(input logic m, input logic d);
    tms = m;
    tdi = d;
    #8 tck = 1'b1;
    #15 tck = 1'b0;
    #7;
  endtask : step
endmodule : tap_tester

// File: sim/testbench.sv
// self-checking bench for the instruction scan tail of the test access port
module testbench
  import tap_scan_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk;
  logic reset;
  logic tck;
  logic tms;
  logic tdi;
  logic tdo;
  logic tdo_oe_n;
  tap_state_e tap_state;
  instr_t active_instr;
  dr_t data_reg;
  instr_t sys_instr;
  logic sys_instr_strobe;
  int error_cnt;
  int tests_run;

  tap_tester i_tester (.tck(tck), .tms(tms), .tdi(tdi));
  tap_instruction_scan_tail i_dut (
    .clk(clk), .reset(reset), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo(tdo), .tdo_oe_n(tdo_oe_n), .tap_state(tap_state),
    .active_instr(active_instr), .data_reg(data_reg),
    .sys_instr(sys_instr), .sys_instr_strobe(sys_instr_strobe)
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic summarize();
    $display("mismatches=%0d checks=%0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : summarize

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic st(input logic m, input logic d);
    i_tester.step(m, d);
  endtask : st

  // bounded wait for the system-side strobe, then compare the word
  task automatic wait_sys(input instr_t exp);
    int n;
    for (n = 0; n < 20 && sys_instr_strobe !== 1'b1; n++) @(negedge clk);
    if (n == 20) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, sys_instr_strobe, 1'b1);
      summarize();
    end else begin
      chk(sys_instr, exp);
    end
  endtask : wait_sys

  // capture pattern, pause, resume shifting, then update to data select
  task automatic ir_pause_resume();
    st(1, 0); st(1, 0); st(0, 0);
    st(0, 0);
    chk(tdo, 0);
    chk(tdo_oe_n, 0);
    st(0, 1);
    chk(tdo, 0);
    st(0, 0);
    chk(tdo, 1);
    st(1, 0);
    chk(tap_state, EXIT1_IR);
    st(0, 0);
    chk(tap_state, PAUSE_IR);
    st(0, 1);
    chk(tap_state, PAUSE_IR);
    chk(active_instr, INSTR_BYPASS);
    st(1, 0);
    chk(tap_state, EXIT2_IR);
    st(0, 0);
    chk(tap_state, SHIFT_IR);
    st(0, 1); st(0, 0); st(1, 0);
    st(0, 0); st(1, 0);
    chk(active_instr, INSTR_BYPASS);
    st(1, 0);
    chk(tap_state, UPDATE_IR);
    chk(active_instr, INSTR_DATA);
    st(1, 0);
    chk(tap_state, SELECT_DR);
    wait_sys(INSTR_DATA);
  endtask : ir_pause_resume

  // load the data register, then rescan the instruction and watch it hold
  task automatic dr_hold();
    dr_t v;
    v = 8'hA5;
    st(0, 0); st(0, 0);
    for (int i = 0; i < 8; i++) st(i == 7, v[i]);
    st(1, 0);
    chk(data_reg, 8'hA5);
    st(1, 0); st(1, 0); st(0, 0); st(0, 0);
    st(0, 1); st(0, 1); st(1, 1);
    st(0, 0);
    chk(data_reg, 8'hA5);
    st(1, 0);
    chk(data_reg, 8'hA5);
    st(1, 0);
    chk(data_reg, 8'hA5);
    chk(active_instr, INSTR_BYPASS);
    st(0, 0);
    chk(tap_state, RUN_IDLE);
    wait_sys(INSTR_BYPASS);
  endtask : dr_hold

  initial begin
    reset = 1'b1;
    error_cnt = 0;
    tests_run = 0;
    st(1, 0);
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    #1;
    chk(tap_state, TEST_LOGIC_RESET);
    chk(active_instr, INSTR_RESET_VALUE);
    chk(tdo_oe_n, 1);
    st(0, 0);
    chk(tap_state, RUN_IDLE);
    ir_pause_resume();
    dr_hold();
    summarize();
  end
endmodule : testbench
